/* File: hw/llhp_port.sv */
/*
 * Host port pins of a serial-bus link-layer controller: host bus cycle
 * engine, interrupt pin, receive indicators, busy acknowledge selection
 * and the general-purpose clock divider.
 * Assumes host pins and the link system clock are asynchronous to
 * SYS_CLK and that the internal register side answers on SYS_CLK.
 */
// Operation
// [RULE1] Host supplies the bus clock, at most 50 MHz.
// [RULE2] Interrupt output goes low while an interrupt is pending.
// [RULE3] Address is 8 bits; pin 0 carries the most significant bit.
// [RULE4] Async packet received pulses its indicator for one iso clock.
// [RULE5] Iso packet received pulses its indicator for one iso clock.
// [RULE6] Host busy high makes incoming packets get a busy acknowledge.
// [RULE7] Each host bus cycle is acknowledged by driving acknowledge low.
// [RULE8] General-purpose clock is link system clock divided by four.
// [RULE9] Mode pins pick 16/8 bit bus and handshake or fixed timing.
// [RULE10] In 8-bit modes only data pins 8 to 15 carry data.
// [RULE11] Host starts each bus cycle by driving cycle start low.
// [RULE12] Pins 0-7 high byte, 8-15 low byte, low pin is MSB.
// [RULE13] Direction high means read, low means write.
// [RULE14] Handshake: acknowledge after access; fixed: after fixed clocks.
// [RULE15] Data pins driven only during an active read cycle.
module llhp_port
  import llhp_pkg::*;
#(
  parameter int FIXED_BCLKS = FIXED_ACK_BCLKS
) (
  input  wire logic                 SYS_CLK,
  input  wire logic                 NRST,
  input  wire logic                 HOST_BUS_CLK,
  input  wire logic                 CYCLE_START_N,
  input  wire logic                 READ_WRITE_SEL,
  input  wire logic [7:0]           HOST_ADDR,
  input  wire logic [15:0]          HOST_DATA_IN,
  output logic      [15:0]          HOST_DATA_OUT,
  output logic      [15:0]          HOST_DATA_OE,
  input  wire logic                 PORT_MODE_SEL_HI,
  input  wire logic                 PORT_MODE_SEL_LO,
  input  wire logic                 HOST_BUSY_IN,
  output logic                      CYCLE_ACK_N,
  output logic                      INT_N,
  output logic                      ASYNC_RX_PULSE,
  output logic                      ISO_RX_PULSE,
  output logic                      ISO_PORT_CLOCK,
  input  wire logic                 LINK_SYS_CLK,
  output logic                      GP_CLK,
  output llhp_pkg::llhp_req_type    REG_REQ,
  output logic                      REG_REQ_VALID,
  input  wire logic                 REG_ACK,
  input  wire logic [15:0]          REG_RDATA,
  input  wire logic                 INT_REQ,
  input  wire logic                 ASYNC_RX_EVENT,
  input  wire logic                 ISO_RX_EVENT,
  input  wire logic                 RX_ACK_REQ,
  input  wire logic                 GRF_FULL,
  output logic      [3:0]           RX_ACK_CODE,
  output logic                      RX_ACK_VALID
);

  initial begin
    if (FIXED_BCLKS < 1 || FIXED_BCLKS > 15)
      $error("FIXED_BCLKS must be between 1 and 15");
  end

  function automatic logic [7:0] rev8(input logic [7:0] v);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++)
      r[i] = v[7-i];
    return r;
  endfunction

  // Pin i of a byte holds value bit 7-i; pins 0-7 form the high byte
  function automatic logic [15:0] pins16(input logic [15:0] v);
    return {rev8(v[7:0]), rev8(v[15:8])};
  endfunction

  // Synchronised pins
  logic [7:0]  addr_s;
  logic [15:0] din_s;
  logic [4:0]  ctl_s;
  logic        bclk_s;
  logic        cs_s;
  logic        rw_s;
  logic        busy_s;
  logic        sclk_s;
  logic [1:0]  mode_s;

  llhp_sync #(.W(8)) u_sync_addr (
    .SYS_CLK (SYS_CLK),
    .NRST    (NRST),
    .PIN     (HOST_ADDR),
    .SYNC    (addr_s)
  );

  llhp_sync #(.W(16)) u_sync_data (
    .SYS_CLK (SYS_CLK),
    .NRST    (NRST),
    .PIN     (HOST_DATA_IN),
    .SYNC    (din_s)
  );

  // Cycle start resets to high so no cycle is seen during reset
  llhp_sync #(.W(5)) u_sync_ctl (
    .SYS_CLK (SYS_CLK),
    .NRST    (NRST),
    .PIN     ({HOST_BUS_CLK, ~CYCLE_START_N, READ_WRITE_SEL,
               HOST_BUSY_IN, LINK_SYS_CLK}),
    .SYNC    (ctl_s)
  );

  llhp_sync #(.W(2)) u_sync_mode (
    .SYS_CLK (SYS_CLK),
    .NRST    (NRST),
    .PIN     ({PORT_MODE_SEL_HI, PORT_MODE_SEL_LO}),
    .SYNC    (mode_s)
  );

  assign bclk_s = ctl_s[4];
  assign cs_s   = ctl_s[3];
  assign rw_s   = ctl_s[2];
  assign busy_s = ctl_s[1];
  assign sclk_s = ctl_s[0];

  // Edge detection on synchronised clocks
  logic bclk_d_q;
  logic sclk_d_q;
  logic bclk_rise;
  logic sclk_rise;

  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      bclk_d_q <= 1'b0;
      sclk_d_q <= 1'b0;
    end else begin
      bclk_d_q <= bclk_s;
      sclk_d_q <= sclk_s;
    end
  end

  assign bclk_rise = bclk_s & ~bclk_d_q;
  assign sclk_rise = sclk_s & ~sclk_d_q;

  // Host cycle engine
  llhp_state_type state_q, state_d;
  llhp_req_type   req_q, req_d;
  logic           req_v_q, req_v_d;
  logic           pend_q, pend_d;
  logic           fixed_q, fixed_d;
  logic           bytem_q, bytem_d;
  logic [3:0]     bcnt_q, bcnt_d;
  logic [15:0]    rdata_q, rdata_d;
  logic           ack_q, ack_d;

  always_comb begin
    state_d = state_q;
    req_d   = req_q;
    req_v_d = 1'b0;
    pend_d  = pend_q;
    fixed_d = fixed_q;
    bytem_d = bytem_q;
    bcnt_d  = bcnt_q;
    rdata_d = rdata_q;
    ack_d   = 1'b0;
    if (pend_q && REG_ACK) begin
      pend_d = 1'b0;
      if (!req_q.we)
        rdata_d = REG_RDATA;
    end
    case (state_q)
      ST_IDLE: begin
        if (bclk_rise && cs_s) begin
          fixed_d       = mode_s[0];   // [RULE9]
          bytem_d       = mode_s[1];   // [RULE9]
          req_d.we      = ~rw_s;
          req_d.byte_mode = mode_s[1];
          req_d.addr    = rev8(addr_s); // [RULE3]
          // [RULE10] [RULE12]
          req_d.wdata   = mode_s[1] ? {8'h00, rev8(din_s[15:8])}
                                    : pins16(din_s);
          req_v_d       = 1'b1;
          pend_d        = 1'b1;
          bcnt_d        = 4'h0;
          state_d       = ST_ACCESS;
        end
      end
      ST_ACCESS: begin
        if (bclk_rise)
          bcnt_d = bcnt_q + 4'h1;
        // [RULE14]
        if (fixed_q) begin
          if (bcnt_q >= 4'(FIXED_BCLKS)) begin
            state_d = ST_ACK;
          end
        end else if (!pend_d) begin
          state_d = ST_ACK;
        end
      end
      ST_ACK: begin
        ack_d = 1'b1;                  // [RULE7]
        if (!cs_s) begin
          ack_d   = 1'b0;
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      state_q <= ST_IDLE;
      req_q   <= '0;
      req_v_q <= 1'b0;
      pend_q  <= 1'b0;
      fixed_q <= 1'b0;
      bytem_q <= 1'b0;
      bcnt_q  <= 4'h0;
      rdata_q <= DATA_RST;
      ack_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      req_q   <= req_d;
      req_v_q <= req_v_d;
      pend_q  <= pend_d;
      fixed_q <= fixed_d;
      bytem_q <= bytem_d;
      bcnt_q  <= bcnt_d;
      rdata_q <= rdata_d;
      ack_q   <= ack_d;
    end
  end

  assign REG_REQ       = req_q;
  assign REG_REQ_VALID = req_v_q;
  assign CYCLE_ACK_N   = ~ack_q;

  // Read data: in byte mode the low byte goes out on pins 8 to 15
  assign HOST_DATA_OUT = bytem_q ? {rev8(rdata_q[7:0]), 8'h00}
                                 : pins16(rdata_q);  // [RULE12]
  // Drive released two SYS_CLK cycles after cycle start rises or direction drops [RULE15]
  assign HOST_DATA_OE  = (cs_s && rw_s && state_q != ST_IDLE)
                         ? (bytem_q ? LOW_LANE_OE : FULL_OE)  // [RULE10]
                         : 16'h0000;

  // Interrupt, busy acknowledge, indicators and clocks
  logic       int_q, int_d;
  logic [3:0] ackc_q, ackc_d;
  logic       ackv_q, ackv_d;
  logic [2:0] iso_cnt_q, iso_cnt_d;
  logic       iso_clk_q, iso_clk_d;
  logic       apend_q, apend_d;
  logic       ipend_q, ipend_d;
  logic       apulse_q, apulse_d;
  logic       ipulse_q, ipulse_d;
  logic       sdiv_q, sdiv_d;
  logic       gp_q, gp_d;
  logic       iso_start;

  assign iso_start = (iso_cnt_q == 3'(ISO_DIV - 1));

  always_comb begin
    int_d  = INT_REQ;                          // [RULE2]
    ackv_d = RX_ACK_REQ;
    ackc_d = ackc_q;
    if (RX_ACK_REQ)
      ackc_d = (busy_s || GRF_FULL) ? ACK_BUSY : ACK_COMPLETE; // [RULE6]
    iso_cnt_d = iso_start ? 3'h0 : iso_cnt_q + 3'h1;
    iso_clk_d = (iso_cnt_d < 3'(ISO_DIV / 2));
    apulse_d  = apulse_q;
    ipulse_d  = ipulse_q;
    apend_d   = apend_q;
    ipend_d   = ipend_q;
    // Pulses span one whole iso clock period [RULE4] [RULE5]
    if (iso_start) begin
      apulse_d = apend_q;
      ipulse_d = ipend_q;
      apend_d  = 1'b0;
      ipend_d  = 1'b0;
    end
    // An event in the consuming cycle is kept for the next period
    if (ASYNC_RX_EVENT)
      apend_d = 1'b1;
    if (ISO_RX_EVENT)
      ipend_d = 1'b1;
    sdiv_d = sdiv_q;
    gp_d   = gp_q;
    if (sclk_rise) begin
      sdiv_d = ~sdiv_q;
      if (sdiv_q)
        gp_d = ~gp_q;                          // [RULE8]
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      int_q     <= 1'b0;
      ackc_q    <= ACK_COMPLETE;
      ackv_q    <= 1'b0;
      iso_cnt_q <= 3'h0;
      iso_clk_q <= 1'b1;
      apend_q   <= 1'b0;
      ipend_q   <= 1'b0;
      apulse_q  <= 1'b0;
      ipulse_q  <= 1'b0;
      sdiv_q    <= 1'b0;
      gp_q      <= 1'b0;
    end else begin
      int_q     <= int_d;
      ackc_q    <= ackc_d;
      ackv_q    <= ackv_d;
      iso_cnt_q <= iso_cnt_d;
      iso_clk_q <= iso_clk_d;
      apend_q   <= apend_d;
      ipend_q   <= ipend_d;
      apulse_q  <= apulse_d;
      ipulse_q  <= ipulse_d;
      sdiv_q    <= sdiv_d;
      gp_q      <= gp_d;
    end
  end

  assign INT_N          = ~int_q;
  assign RX_ACK_CODE    = ackc_q;
  assign RX_ACK_VALID   = ackv_q;
  assign ISO_PORT_CLOCK = iso_clk_q;
  assign ASYNC_RX_PULSE = apulse_q;
  assign ISO_RX_PULSE   = ipulse_q;
  assign GP_CLK         = gp_q;

  property p_int;
    @(posedge SYS_CLK) disable iff (!NRST)
      INT_REQ |=> !INT_N;
  endproperty
  a_int: assert property (p_int) else $error("interrupt not low"); // [RULE2]

  property p_async;
    @(posedge SYS_CLK) disable iff (!NRST)
      $changed(ASYNC_RX_PULSE) |-> $past(iso_start);
  endproperty
  a_async: assert property (p_async) else $error("async pulse width"); // [RULE4]

  property p_iso;
    @(posedge SYS_CLK) disable iff (!NRST)
      $rose(ISO_RX_PULSE) |-> $past(iso_start) ##0 ISO_RX_PULSE[*8];
  endproperty
  a_iso: assert property (p_iso) else $error("iso pulse width"); // [RULE5]

  property p_busy;
    @(posedge SYS_CLK) disable iff (!NRST)
      RX_ACK_REQ && busy_s |=> RX_ACK_VALID && RX_ACK_CODE == ACK_BUSY;
  endproperty
  a_busy: assert property (p_busy) else $error("busy ack missing"); // [RULE6]

  property p_ack;
    @(posedge SYS_CLK) disable iff (!NRST)
      $fell(CYCLE_ACK_N) |-> $past(state_q == ST_ACK) && $past(cs_s, 2);
  endproperty
  a_ack: assert property (p_ack) else $error("ack without cycle"); // [RULE7]

  property p_gpclk;
    @(posedge SYS_CLK) disable iff (!NRST)
      $changed(GP_CLK) |-> $past(sclk_rise) && $past(sdiv_q);
  endproperty
  a_gpclk: assert property (p_gpclk) else $error("gp clock ratio"); // [RULE8]

  property p_oe;
    @(posedge SYS_CLK) disable iff (!NRST)
      HOST_DATA_OE != 16'h0000 |-> cs_s && rw_s
        && (!bytem_q || HOST_DATA_OE[7:0] == 8'h00);
  endproperty
  a_oe: assert property (p_oe) else $error("data driven outside read"); // [RULE15]

  property p_hs;
    @(posedge SYS_CLK) disable iff (!NRST)
      !fixed_q && pend_q |-> CYCLE_ACK_N;
  endproperty
  a_hs: assert property (p_hs) else $error("ack before access done"); // [RULE14]

  property p_addr;
    @(posedge SYS_CLK) disable iff (!NRST)
      REG_REQ_VALID |-> REG_REQ.addr[7] == $past(addr_s[0])
        && REG_REQ.addr[0] == $past(addr_s[7]);
  endproperty
  a_addr: assert property (p_addr) else $error("address bit order"); // [RULE3]

endmodule

/* File: hw/llhp_pkg.sv */
/*
 * Shared constants and types of the link-layer host port pins block.
 * Assumes a 200 MHz system clock that samples every host-side pin.
 */
package llhp_pkg;

  localparam int          SYS_CLK_MHZ      = 200;
  localparam int          BCLK_MAX_MHZ     = 50;
  // Host bus clock must give at least four samples per period
  localparam int          BCLK_MIN_SAMPLES = SYS_CLK_MHZ / BCLK_MAX_MHZ;
  localparam int          ISO_CLK_MHZ      = 25;
  localparam int          ISO_DIV          = SYS_CLK_MHZ / ISO_CLK_MHZ;
  localparam int          SCLK_DIV         = 4;
  localparam int          FIXED_ACK_BCLKS  = 3;

  localparam logic [1:0]  MODE_W16_HS      = 2'h0;
  localparam logic [1:0]  MODE_W16_FIX     = 2'h1;
  localparam logic [1:0]  MODE_W8_HS       = 2'h2;
  localparam logic [1:0]  MODE_W8_FIX      = 2'h3;

  localparam logic [3:0]  ACK_COMPLETE     = 4'h1;
  localparam logic [3:0]  ACK_BUSY         = 4'h4;

  localparam logic [15:0] DATA_RST         = 16'h0000;
  localparam logic [15:0] LOW_LANE_OE      = 16'hFF00;
  localparam logic [15:0] FULL_OE          = 16'hFFFF;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ACCESS,
    ST_ACK
  } llhp_state_type;

  typedef struct packed {
    logic        we;
    logic        byte_mode;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } llhp_req_type;

endpackage

/* File: hw/llhp_sync.sv */
/*
 * Two-flop synchroniser for a group of pins.
 * Assumes the bits of the group are stable around the sampling edge
 * they are used on; no bit-to-bit coherence is promised.
 */
module llhp_sync #(
  parameter int W = 1
) (
  input  wire logic         SYS_CLK,
  input  wire logic         NRST,
  input  wire logic [W-1:0] PIN,
  output logic      [W-1:0] SYNC
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= PIN;
      sync_q <= meta_q;
    end
  end

  assign SYNC = sync_q;
endmodule

/* File: hw/llhp_dummy_removed.sv */
/*
 * Reserved file of the host port pins block; it holds no logic.
 * Assumes nothing.
 */

/* File: dv/llhp_host_model.sv */
/*
 * Host microcontroller model: bus clock, cycle start, direction,
 * address and data pins of the host port.
 * Assumes the bench calls bus_cycle and SYS_CLK times every drive.
 */
module llhp_host_model (
  input  wire logic        SYS_CLK,
  output logic             HOST_BUS_CLK,
  output logic             CYCLE_START_N,
  output logic             READ_WRITE_SEL,
  output logic [7:0]       HOST_ADDR,
  output logic [15:0]      HOST_DATA_IN,
  input  wire logic [15:0] HOST_DATA_OUT,
  input  wire logic [15:0] HOST_DATA_OE,
  input  wire logic        CYCLE_ACK_N
);
  timeunit 1ns;
  timeprecision 100ps;
  logic        drv_en = 1'h0;
  logic [15:0] drv_val = 16'h0000;
  logic [15:0] last_q = 16'h0000;

  initial begin
    HOST_BUS_CLK = 1'h0;
    CYCLE_START_N = 1'h1;
    READ_WRITE_SEL = 1'h1;
    HOST_ADDR = 8'h00;
  end
  // Fastest bus clock allowed, to stress the pin sampling
  always #10 HOST_BUS_CLK = ~HOST_BUS_CLK;
  // Released pins flip every cycle so stale data never looks valid
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      HOST_DATA_IN[i] = HOST_DATA_OE[i] ? HOST_DATA_OUT[i]
                      : (drv_en ? drv_val[i] : ~last_q[i]);
    end
  end
  always @(negedge SYS_CLK) last_q <= HOST_DATA_IN;

  task automatic bus_cycle(input logic rd, input logic [7:0] addr,
                           input logic [15:0] wdat,
                           output logic [15:0] rdat,
                           output logic [15:0] oe, output logic ok);
    int n;
    ok = 1'h0;
    rdat = 16'h0000;
    oe = 16'h0000;
    @(negedge HOST_BUS_CLK);
    @(negedge SYS_CLK);
    HOST_ADDR = addr;
    READ_WRITE_SEL = rd;
    drv_val = wdat;
    drv_en = ~rd;
    CYCLE_START_N = 1'h0;
    for (n = 0; n < 2000 && !ok; n++) begin
      @(negedge SYS_CLK);
      if (CYCLE_ACK_N === 1'h0) begin
        ok = 1'h1;
        rdat = HOST_DATA_IN;
        oe = HOST_DATA_OE;
      end
    end
    // Cycle ends once the acknowledge was seen, or after 2000 cycles without it
    @(negedge SYS_CLK);
    CYCLE_START_N = 1'h1;
    drv_en = 1'h0;
    for (n = 0; n < 50 && CYCLE_ACK_N !== 1'h1; n++) @(negedge SYS_CLK);
    if (CYCLE_ACK_N !== 1'h1) ok = 1'h0;
  endtask
endmodule

/* File: dv/llhp_port_test.sv */
/*
 * Self-checking bench of the host port pins block.
 * Assumes llhp_pkg, llhp_port and llhp_host_model are compiled first.
 */
module llhp_port_test;
  import llhp_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int FIX_N  = 2;
  localparam int GP_CYC = 4 * 160 / 5;
  logic         SYS_CLK = 1'h0;
  logic         NRST, HOST_BUS_CLK, CYCLE_START_N, READ_WRITE_SEL;
  logic [7:0]   HOST_ADDR;
  logic [15:0]  HOST_DATA_IN, HOST_DATA_OUT, HOST_DATA_OE, REG_RDATA;
  logic         PORT_MODE_SEL_HI, PORT_MODE_SEL_LO, HOST_BUSY_IN;
  logic         CYCLE_ACK_N, INT_N, ASYNC_RX_PULSE, ISO_RX_PULSE;
  logic         ISO_PORT_CLOCK, LINK_SYS_CLK, GP_CLK, REG_REQ_VALID;
  logic         REG_ACK, INT_REQ, ASYNC_RX_EVENT, ISO_RX_EVENT;
  logic         RX_ACK_REQ, GRF_FULL, RX_ACK_VALID;
  logic [3:0]   RX_ACK_CODE;
  llhp_req_type REG_REQ, last_req;
  int           fail_count = 0, num_checks = 0, ack_dly = 1, early = 0;
  logic [15:0]  rd_val = 16'h0000;

  always #2.5 SYS_CLK = ~SYS_CLK;
  initial begin
    LINK_SYS_CLK = 1'h0;
    #1.3;
    forever #80 LINK_SYS_CLK = ~LINK_SYS_CLK;
  end

  llhp_port #(.FIXED_BCLKS(FIX_N)) i_dut (
    .SYS_CLK(SYS_CLK), .NRST(NRST), .HOST_BUS_CLK(HOST_BUS_CLK),
    .CYCLE_START_N(CYCLE_START_N), .READ_WRITE_SEL(READ_WRITE_SEL),
    .HOST_ADDR(HOST_ADDR), .HOST_DATA_IN(HOST_DATA_IN),
    .HOST_DATA_OUT(HOST_DATA_OUT), .HOST_DATA_OE(HOST_DATA_OE),
    .PORT_MODE_SEL_HI(PORT_MODE_SEL_HI),
    .PORT_MODE_SEL_LO(PORT_MODE_SEL_LO), .HOST_BUSY_IN(HOST_BUSY_IN),
    .CYCLE_ACK_N(CYCLE_ACK_N), .INT_N(INT_N),
    .ASYNC_RX_PULSE(ASYNC_RX_PULSE), .ISO_RX_PULSE(ISO_RX_PULSE),
    .ISO_PORT_CLOCK(ISO_PORT_CLOCK), .LINK_SYS_CLK(LINK_SYS_CLK),
    .GP_CLK(GP_CLK), .REG_REQ(REG_REQ), .REG_REQ_VALID(REG_REQ_VALID),
    .REG_ACK(REG_ACK), .REG_RDATA(REG_RDATA), .INT_REQ(INT_REQ),
    .ASYNC_RX_EVENT(ASYNC_RX_EVENT), .ISO_RX_EVENT(ISO_RX_EVENT),
    .RX_ACK_REQ(RX_ACK_REQ), .GRF_FULL(GRF_FULL),
    .RX_ACK_CODE(RX_ACK_CODE), .RX_ACK_VALID(RX_ACK_VALID)
  );
  llhp_host_model i_host (
    .SYS_CLK(SYS_CLK), .HOST_BUS_CLK(HOST_BUS_CLK),
    .CYCLE_START_N(CYCLE_START_N), .READ_WRITE_SEL(READ_WRITE_SEL),
    .HOST_ADDR(HOST_ADDR), .HOST_DATA_IN(HOST_DATA_IN),
    .HOST_DATA_OUT(HOST_DATA_OUT), .HOST_DATA_OE(HOST_DATA_OE),
    .CYCLE_ACK_N(CYCLE_ACK_N)
  );

  // Internal register side; counts acknowledges that beat its answer
  initial begin
    REG_ACK = 1'h0;
    REG_RDATA = 16'h0000;
    forever begin
      @(negedge SYS_CLK);
      if (REG_REQ_VALID === 1'h1) begin
        last_req = REG_REQ;
        repeat (ack_dly) begin
          @(negedge SYS_CLK);
          if (CYCLE_ACK_N === 1'h0) early++;
        end
        REG_RDATA = rd_val;
        REG_ACK = 1'h1;
        @(negedge SYS_CLK);
        REG_ACK = 1'h0;
        REG_RDATA = ~rd_val;
      end
    end
  end

  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic stall(input string what);
    fail_count++;
    $display("Error %s expected ack seen timeout", what);
    wrap_up();
  endtask

  function automatic logic [15:0] rev16(input logic [15:0] v);
    for (int i = 0; i < 16; i++) rev16[15 - i] = v[i];
  endfunction

  task automatic t_mode(input logic [1:0] m);
    logic [15:0] rd, oe, msk, wm;
    logic        ok;
    msk = m[1] ? LOW_LANE_OE : FULL_OE;
    wm = m[1] ? 16'h00FF : 16'hFFFF;
    {PORT_MODE_SEL_HI, PORT_MODE_SEL_LO} = m;
    repeat (4) @(negedge SYS_CLK);
    early = 0;
    ack_dly = m[0] ? 60 : 20;
    i_host.bus_cycle(1'h0, 8'h35, 16'hC2A7, rd, oe, ok);
    if (ok !== 1'h1) stall("write");
    check("early ack", 16'(m[0]), 16'(early != 0));
    check("write oe", 16'h0000, oe);
    check("we", 16'h0001, 16'(last_req.we));
    check("byte mode", 16'(m[1]), 16'(last_req.byte_mode));
    check("addr", rev16(16'h3500), 16'(last_req.addr));
    check("wdata", rev16(16'hC2A7) & wm, last_req.wdata);
    repeat (70) @(negedge SYS_CLK);
    ack_dly = 1;
    rd_val = 16'h5A3C;
    i_host.bus_cycle(1'h1, 8'hCA, 16'h0000, rd, oe, ok);
    if (ok !== 1'h1) stall("read");
    check("we", 16'h0000, 16'(last_req.we));
    check("read oe", msk, oe);
    check("rdata", rev16(16'h5A3C) & msk, rd & msk);
    @(negedge SYS_CLK);
    check("oe after", 16'h0000, HOST_DATA_OE);
  endtask

  task automatic t_pulse(input logic iso);
    int n;
    if (iso) ISO_RX_EVENT = 1'h1;
    else ASYNC_RX_EVENT = 1'h1;
    @(negedge SYS_CLK);
    ISO_RX_EVENT = 1'h0;
    ASYNC_RX_EVENT = 1'h0;
    for (n = 0; n < 12 && (iso ? ISO_RX_PULSE : ASYNC_RX_PULSE) !== 1'h1;
         n++) @(negedge SYS_CLK);
    for (n = 0; n < 20 && (iso ? ISO_RX_PULSE : ASYNC_RX_PULSE) === 1'h1;
         n++) @(negedge SYS_CLK);
    check(iso ? "iso pulse" : "async pulse", 16'(ISO_DIV), 16'(n));
  endtask

  task automatic t_busy(input logic b, input logic f, input logic [3:0] c);
    HOST_BUSY_IN = b;
    GRF_FULL = f;
    repeat (4) @(negedge SYS_CLK);
    RX_ACK_REQ = 1'h1;
    @(negedge SYS_CLK);
    check("ack valid", 16'h0001, 16'(RX_ACK_VALID));
    check("ack code", 16'(c), 16'(RX_ACK_CODE));
    RX_ACK_REQ = 1'h0;
    @(negedge SYS_CLK);
    check("ack valid end", 16'h0000, 16'(RX_ACK_VALID));
  endtask

  task automatic t_misc();
    int n, hi;
    INT_REQ = 1'h1;
    repeat (2) @(negedge SYS_CLK);
    check("int low", 16'h0000, 16'(INT_N));
    INT_REQ = 1'h0;
    repeat (2) @(negedge SYS_CLK);
    check("int high", 16'h0001, 16'(INT_N));
    for (n = 0; n < 300 && GP_CLK !== 1'h0; n++) @(negedge SYS_CLK);
    for (n = 0; n < 300 && GP_CLK !== 1'h1; n++) @(negedge SYS_CLK);
    for (hi = 0; hi < 300 && GP_CLK === 1'h1; hi++) @(negedge SYS_CLK);
    for (n = 0; n < 300 && GP_CLK !== 1'h1; n++) @(negedge SYS_CLK);
    check("gp period", 16'h0001,
          16'((hi + n) inside {[GP_CYC - 1:GP_CYC + 1]}));
    // Indicator pulses are timed by this clock, so its duty is checked
    for (n = 0; n < 20 && ISO_PORT_CLOCK !== 1'h0; n++) @(negedge SYS_CLK);
    for (n = 0; n < 20 && ISO_PORT_CLOCK !== 1'h1; n++) @(negedge SYS_CLK);
    for (hi = 0; hi < 20 && ISO_PORT_CLOCK === 1'h1; hi++)
      @(negedge SYS_CLK);
    check("iso clock high", 16'(ISO_DIV / 2), 16'(hi));
  endtask

  initial begin
    NRST = 1'h0;
    {PORT_MODE_SEL_HI, PORT_MODE_SEL_LO, HOST_BUSY_IN, GRF_FULL} = 4'h0;
    {INT_REQ, ASYNC_RX_EVENT, ISO_RX_EVENT, RX_ACK_REQ} = 4'h0;
    repeat (5) @(posedge SYS_CLK);
    @(negedge SYS_CLK);
    check("ack reset", 16'h0001, 16'(CYCLE_ACK_N));
    check("int reset", 16'h0001, 16'(INT_N));
    check("oe reset", 16'h0000, HOST_DATA_OE);
    NRST = 1'h1;
    repeat (4) @(negedge SYS_CLK);
    for (int m = 0; m < 4; m++) t_mode(2'(m));
    t_pulse(1'h0);
    t_pulse(1'h1);
    t_busy(1'h0, 1'h0, ACK_COMPLETE);
    t_busy(1'h1, 1'h0, ACK_BUSY);
    t_busy(1'h0, 1'h1, ACK_BUSY);
    t_busy(1'h1, 1'h1, ACK_BUSY);
    t_busy(1'h0, 1'h0, ACK_COMPLETE);
    t_misc();
    wrap_up();
  end
endmodule
